// ===== pmcr_regs.svh
// Register offsets, field positions and reset values for the page and memory config bank
`ifndef PMCR_REGS_SVH
`define PMCR_REGS_SVH

`define PMCR_ADDR_W        8
`define PMCR_PAGE_OFS      8'he0
`define PMCR_MEMST0_OFS    8'hf0
`define PMCR_MEMST1_OFS    8'hf1
`define PMCR_PAGE_RST      8'h00
`define PMCR_SRAM_MSB      7
`define PMCR_SRAM_LSB      4
`define PMCR_FLASH_MSB     3
`define PMCR_FLASH_LSB     0
`define PMCR_BTYPE_MSB     5
`define PMCR_BTYPE_LSB     4
`define PMCR_BSIZE_MSB     3
`define PMCR_BSIZE_LSB     0
`define PMCR_ST1_PAD       2'h0

`endif

// ===== pmcr_pkg.sv
// Types for the page and memory config bank
package pmcr_pkg;
    // SRAM size codes
    typedef enum logic [3:0] {
        PMCR_SRAM_NONE = 4'h0,
        PMCR_SRAM_16K  = 4'h1,
        PMCR_SRAM_32K  = 4'h2,
        PMCR_SRAM_64K  = 4'h3
    } pmcr_sram_type;
    // Main flash size codes
    typedef enum logic [3:0] {
        PMCR_FLASH_NONE = 4'h0,
        PMCR_FLASH_256K = 4'h1,
        PMCR_FLASH_512K = 4'h2,
        PMCR_FLASH_1M   = 4'h3,
        PMCR_FLASH_2M   = 4'h4,
        PMCR_FLASH_4M   = 4'h5,
        PMCR_FLASH_8M   = 4'h6
    } pmcr_flash_type;
    // Boot block size codes
    typedef enum logic [3:0] {
        PMCR_BOOT_NONE = 4'h0,
        PMCR_BOOT_128K = 4'h1,
        PMCR_BOOT_256K = 4'h2,
        PMCR_BOOT_512K = 4'h3
    } pmcr_boot_type;
    // Boot block technology codes
    typedef enum logic [1:0] {
        PMCR_BOOT_FLASH  = 2'h0,
        PMCR_BOOT_EEPROM = 2'h1
    } pmcr_btech_type;
endpackage

// ===== pmcr_sync.sv
// Three-stage synchroniser for bus strobes arriving from pins
`timescale 1ns/10ps
`default_nettype none
module pmcr_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         rstn_i,
    // Raw and synchronised levels
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o,
    output logic      [W-1:0] stable_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // First stage feeds only the second
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // A change counts once stages two and three agree
    assign sync_o   = s3_reg;
    assign stable_o = ~(s2_reg ^ s3_reg);
endmodule
`default_nettype wire

// ===== pmcr_top.sv
// Page select register and memory layout status registers on the MCU data bus
// How it works
// - An eight-bit page register extends MCU addressing to up to 256 pages.
// - The page register is read and written by the MCU at offset e0 of the config space.
// - All eight page bits leave the block toward the address decode array.
// - The same eight page bits also reach the general logic array for spare use.
// - Two read-only 8-bit memory status registers ignore every write.
// - Status 0 holds SRAM size in bits 7..4 and main flash size in bits 3..0.
// - The main flash size code runs 0 none through 6 for 8M bits.
// - Status 1 holds boot block size in bits 3..0 and boot type in bits 5..4.
// - Bits 7 and 6 of status 1 read as zero.
`include "pmcr_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module pmcr_top #(
    parameter logic [3:0] SRAM_SIZE  = pmcr_pkg::PMCR_SRAM_64K,
    parameter logic [3:0] FLASH_SIZE = pmcr_pkg::PMCR_FLASH_4M,
    parameter logic [3:0] BOOT_SIZE  = pmcr_pkg::PMCR_BOOT_256K,
    parameter logic [1:0] BOOT_TECH  = pmcr_pkg::PMCR_BOOT_FLASH
) (
    // Clock and reset
    input  wire logic                     mclk_i,
    input  wire logic                     rstn_i,
    // MCU bus from pins
    input  wire logic [`PMCR_ADDR_W-1:0]  addr_i,
    input  wire logic                     cfg_sel_i,
    input  wire logic                     wr_n_i,
    input  wire logic                     rd_n_i,
    input  wire logic [7:0]               wdata_i,
    // Read data bus, eight data bits and one shared drive enable
    output logic      [7:0]               rdata_o,
    output logic                          rdata_oe_o,
    // Page bits to the logic arrays
    output logic      [7:0]               address_decode_array_o,
    output logic      [7:0]               general_logic_array_o
);
    // Synchronised strobe levels, active high
    logic [1:0] strb_sync;
    logic [1:0] strb_stable;

    // Qualified strobe state from the previous cycle
    logic       wr_act_reg;
    logic       wr_act_next;
    logic       rd_act_reg;
    logic       rd_act_next;

    // Bus captured while a strobe is seen active
    logic [`PMCR_ADDR_W-1:0] addr_lat_reg;
    logic [`PMCR_ADDR_W-1:0] addr_lat_next;
    logic                    sel_lat_reg;
    logic                    sel_lat_next;
    logic [7:0]              wdat_lat_reg;
    logic [7:0]              wdat_lat_next;

    // Page register and its next value
    logic [7:0] page_select_register_reg;
    logic [7:0] page_select_register_next;

    // Registered read side
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic       oe_reg;
    logic       oe_next;

    // Registered copies toward the two arrays
    logic [7:0] adec_reg;
    logic [7:0] adec_next;
    logic [7:0] glog_reg;
    logic [7:0] glog_next;

    // Offset decode, shared by the write path and the read mux
    function automatic logic offset_hit(
        input logic                    sel,
        input logic [`PMCR_ADDR_W-1:0] addr,
        input logic [`PMCR_ADDR_W-1:0] ofs
    );
        return sel & (addr == ofs);
    endfunction

    // Strobes come from pins, active low inverted to active high
    pmcr_sync #(.W(2)) u_sync (
        .mclk_i   (mclk_i),
        .rstn_i   (rstn_i),
        .async_i  ({~wr_n_i, ~rd_n_i}),
        .sync_o   (strb_sync),
        .stable_o (strb_stable)
    );

    // Qualified strobe levels; a level only counts once stages agree,
    // so a strobe glitch shorter than one cycle never starts an access
    wire wr_now  = strb_stable[1] ? strb_sync[1] : wr_act_reg;
    wire rd_now  = strb_stable[0] ? strb_sync[0] : rd_act_reg;
    wire capture = wr_now | rd_now;

    // Trailing edge of the write strobe, as seen after the synchroniser
    wire wr_end = wr_act_reg & ~wr_now;

    // Offset hits on the latched access
    wire hit_page = offset_hit(sel_lat_reg, addr_lat_reg, `PMCR_PAGE_OFS);
    wire hit_st0  = offset_hit(sel_lat_reg, addr_lat_reg, `PMCR_MEMST0_OFS);
    wire hit_st1  = offset_hit(sel_lat_reg, addr_lat_reg, `PMCR_MEMST1_OFS);

    // Only the page offset accepts writes; status hits are never written
    wire page_wr = wr_end & hit_page;

    // Status words are built from straps; writes never reach them
    wire [7:0] memst0 = {SRAM_SIZE, FLASH_SIZE};
    wire [7:0] memst1 = {`PMCR_ST1_PAD, BOOT_TECH, BOOT_SIZE};

    // Read decode, unselected or unmapped offsets return zero
    wire [7:0] rd_mux = hit_page ? page_select_register_reg :
                        hit_st0  ? memst0 :
                        hit_st1  ? memst1 : 8'h00;

    // Strobe state follows the qualified level every cycle
    assign wr_act_next = wr_now;
    assign rd_act_next = rd_now;

    // Bus frozen once the strobe ends; pins need only outlast the
    // synchroniser, the latched copy serves the trailing-edge load
    assign addr_lat_next = capture ? addr_i : addr_lat_reg;
    assign sel_lat_next  = capture ? cfg_sel_i : sel_lat_reg;
    assign wdat_lat_next = capture ? wdata_i : wdat_lat_reg;

    // Page register loads on the trailing edge of the write strobe
    assign page_select_register_next = page_wr ? wdat_lat_reg :
                                       page_select_register_reg;

    // Read data is zero outside a read so the shared bus sees no stale byte
    assign rdata_next = rd_now ? rd_mux : 8'h00;
    assign oe_next    = rd_now & sel_lat_reg;

    // Both arrays see the same eight bits, one cycle behind the register
    assign adec_next = page_select_register_reg;
    assign glog_next = page_select_register_reg;

    // Write strobe state
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_act_reg <= 1'b0;
        end else begin
            wr_act_reg <= wr_act_next;
        end
    end

    // Read strobe state
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_act_reg <= 1'b0;
        end else begin
            rd_act_reg <= rd_act_next;
        end
    end

    // Latched offset
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_lat_reg <= '0;
        end else begin
            addr_lat_reg <= addr_lat_next;
        end
    end

    // Latched select
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sel_lat_reg <= 1'b0;
        end else begin
            sel_lat_reg <= sel_lat_next;
        end
    end

    // Latched write data
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wdat_lat_reg <= 8'h00;
        end else begin
            wdat_lat_reg <= wdat_lat_next;
        end
    end

    // Page register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            page_select_register_reg <= `PMCR_PAGE_RST;
        end else begin
            page_select_register_reg <= page_select_register_next;
        end
    end

    // Read data
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Read drive enable
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= oe_next;
        end
    end

    // Copy toward the address decode array
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            adec_reg <= `PMCR_PAGE_RST;
        end else begin
            adec_reg <= adec_next;
        end
    end

    // Copy toward the general logic array; own flop keeps fanout local
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            glog_reg <= `PMCR_PAGE_RST;
        end else begin
            glog_reg <= glog_next;
        end
    end

    // Outputs straight from flops
    assign rdata_o                = rdata_reg;
    assign rdata_oe_o             = oe_reg;
    assign address_decode_array_o = adec_reg;
    assign general_logic_array_o  = glog_reg;
endmodule
`default_nettype wire

// ===== pmcr_asserts.sv
// Checker for the page and memory config bank ports
`timescale 1ns/10ps
`default_nettype none
module pmcr_asserts #(
    parameter logic [3:0] SRAM_SIZE  = 4'h0,
    parameter logic [3:0] FLASH_SIZE = 4'h0,
    parameter logic [3:0] BOOT_SIZE  = 4'h0,
    parameter logic [1:0] BOOT_TECH  = 2'h0
) (
    // Clock, reset and bus
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic       cfg_sel_i,
    input  wire logic       wr_n_i,
    input  wire logic       rd_n_i,
    input  wire logic [7:0] wdata_i,
    // Observed outputs
    input  wire logic [7:0] rdata_o,
    input  wire logic       rdata_oe_o,
    input  wire logic [7:0] address_decode_array_o,
    input  wire logic [7:0] general_logic_array_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);
    logic [3:0] since_wr;
    logic [7:0] pg_exp;
    logic       rd_long;
    logic       mapped;
    // Reads are judged only once the strobe has cleared the synchroniser
    assign mapped = addr_i == 8'he0 || addr_i == 8'hf0 || addr_i == 8'hf1;
    // Expected page tracks every selected write to the page offset
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_wr <= 4'hf;
            pg_exp   <= 8'h00;
        end else begin
            since_wr <= !wr_n_i ? 4'h0 : (since_wr == 4'hf ? since_wr : since_wr + 4'h1);
            if (!wr_n_i && cfg_sel_i && addr_i == 8'he0) pg_exp <= wdata_i;
        end
    end
    always_ff @(posedge mclk_i) rd_long <= !rd_n_i && $past(rd_n_i, 5) == 1'b0;
    a_arrays_agree: assert property (address_decode_array_o == general_logic_array_o)
        else $error("page outputs differ between arrays");
    a_page_tracks_writes: assert property (since_wr >= 4'h9 |-> address_decode_array_o == pg_exp)
        else $error("page output differs from last page write");
    a_reset_clears: assert property (!$past(rstn_i) |-> address_decode_array_o == 8'h00 && !rdata_oe_o)
        else $error("outputs not clear after reset");
    a_page_read_back: assert property (rd_long && cfg_sel_i && addr_i == 8'he0 |-> rdata_o == address_decode_array_o)
        else $error("page read returns wrong value");
    a_status0_read: assert property (rd_long && cfg_sel_i && addr_i == 8'hf0 |-> rdata_o == {SRAM_SIZE, FLASH_SIZE})
        else $error("status 0 read wrong");
    a_status1_read: assert property (rd_long && cfg_sel_i && addr_i == 8'hf1 |-> rdata_o == {2'h0, BOOT_TECH, BOOT_SIZE})
        else $error("status 1 read wrong");
    a_read_drives: assert property (rd_long && cfg_sel_i |-> ##0 rdata_oe_o)
        else $error("read drive enable low during read");
    a_unmapped_zero: assert property (rd_long && (!cfg_sel_i || !mapped) |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== pmcr_mcu_model.sv
// Microcontroller model driving the config space strobes
`timescale 1ns/10ps
`default_nettype none
module pmcr_mcu_model (
    // Clock and read answer
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    // Bus toward the block
    output logic      [7:0] addr_o,
    output logic            sel_o,
    output logic            wr_n_o,
    output logic            rd_n_o,
    output logic      [7:0] wdata_o
);
    initial begin
        addr_o  = 8'h00;
        sel_o   = 1'b0;
        wr_n_o  = 1'b1;
        rd_n_o  = 1'b1;
        wdata_o = 8'h00;
    end
    // One access; bus held 6 cycles past the strobe to outlast the sync
    task automatic xfer(input logic [7:0] a, input logic s, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
        @(posedge mclk_i) #1;
        addr_o  = a;
        sel_o   = s;
        wdata_o = d;
        wr_n_o  = !w;
        rd_n_o  = w;
        repeat (6) @(posedge mclk_i);
        #1;
        q = rdata_i; // Settled value, clear of the launching edge
        wr_n_o = 1'b1;
        rd_n_o = 1'b1;
        repeat (6) @(posedge mclk_i);
        #1;
        addr_o  = ~a; // Released bus shows the inverse, never the old value
        sel_o   = 1'b0;
        wdata_o = ~d;
        repeat (6) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// ===== tb_page_and_memory_config_regs.sv
// Self-checking bench for the page and memory config bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_page_and_memory_config_regs;
    logic       mclk_i, rstn_i, cfg_sel_i, wr_n_i, rd_n_i, rdata_oe_o;
    logic [7:0] addr_i, wdata_i, rdata_o, address_decode_array_o, general_logic_array_o, q;
    logic [7:0] pv [3] = '{8'ha5, 8'h5a, 8'hff};
    int         n_mismatch = 0;
    int         comparisons = 0;
    // Non-default codes so every status field is exercised
    pmcr_top #(.SRAM_SIZE(4'h2), .FLASH_SIZE(4'h6), .BOOT_SIZE(4'h3), .BOOT_TECH(2'h1)) i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .cfg_sel_i(cfg_sel_i),
        .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
        .rdata_oe_o(rdata_oe_o), .address_decode_array_o(address_decode_array_o),
        .general_logic_array_o(general_logic_array_o));
    pmcr_mcu_model i_mcu (.mclk_i(mclk_i), .rdata_i(rdata_o), .addr_o(addr_i),
        .sel_o(cfg_sel_i), .wr_n_o(wr_n_i), .rd_n_o(rd_n_i), .wdata_o(wdata_i));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end
    initial begin
        #20us;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        rstn_i = 1'b0;
        repeat (20) @(posedge mclk_i);
        #1 rstn_i = 1'b1;
        i_mcu.xfer(8'he0, 1'b1, 1'b0, 8'h00, q);
        `CHK("page after reset", 8'h00, q)
        foreach (pv[k]) begin
            i_mcu.xfer(8'he0, 1'b1, 1'b1, pv[k], q);
            i_mcu.xfer(8'he0, 1'b1, 1'b0, 8'h00, q);
            `CHK("page read", pv[k], q)
            `CHK("decode out", pv[k], address_decode_array_o)
            `CHK("logic out", pv[k], general_logic_array_o)
        end
        // Writes that must be ignored: status offsets and unselected page
        i_mcu.xfer(8'hf0, 1'b1, 1'b1, 8'h00, q);
        i_mcu.xfer(8'hf1, 1'b1, 1'b1, 8'hff, q);
        i_mcu.xfer(8'he0, 1'b0, 1'b1, 8'h00, q);
        i_mcu.xfer(8'hf0, 1'b1, 1'b0, 8'h00, q);
        `CHK("status 0", 8'h26, q)
        i_mcu.xfer(8'hf1, 1'b1, 1'b0, 8'h00, q);
        `CHK("status 1", 8'h13, q)
        `CHK("page kept", 8'hff, general_logic_array_o)
        i_mcu.xfer(8'h7e, 1'b1, 1'b0, 8'h00, q);
        `CHK("unmapped read", 8'h00, q)
        @(posedge mclk_i) #1 rstn_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 rstn_i = 1'b1;
        @(posedge mclk_i) #1;
        `CHK("page after reset", 8'h00, address_decode_array_o)
        tally_and_finish();
    end
endmodule
bind pmcr_top pmcr_asserts #(.SRAM_SIZE(SRAM_SIZE), .FLASH_SIZE(FLASH_SIZE),
    .BOOT_SIZE(BOOT_SIZE), .BOOT_TECH(BOOT_TECH)) i_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .addr_i(addr_i), .cfg_sel_i(cfg_sel_i),
    .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
    .rdata_oe_o(rdata_oe_o), .address_decode_array_o(address_decode_array_o),
    .general_logic_array_o(general_logic_array_o));
`default_nettype wire
